// ===== design/sipm_pkg.sv
// sipm_pkg: constants and types for the status indicator and power mode block
// assumes a 100 MHz core clock; only the millisecond tick is converted to cycles here
package sipm_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1000;
  // indicator phase times in ms
  localparam int unsigned SLOW_ON_MS = 200;
  localparam int unsigned SLOW_OFF_MS = 1800;
  localparam int unsigned STBY_ON_MS = 1800;
  localparam int unsigned STBY_OFF_MS = 200;
  localparam int unsigned FAST_MS = 120;
  localparam int unsigned REG_WINDOW_S = 15;
  localparam int unsigned REG_WINDOW_MS = REG_WINDOW_S * 1000;
  localparam int unsigned SLEEP_DELAY_UNIT_MS = 1000;
  // reset values
  localparam logic [7:0] SLEEP_DELAY_RST = 8'h00;
  localparam logic SLEEP_POL_RST = 1'b0;
  // function command values
  localparam logic [3:0] FUNC_FULL = 4'h1;
  localparam logic [3:0] FUNC_FLIGHT = 4'h4;
  // adc
  localparam int unsigned ADC_BITS = 12;

  typedef enum logic [1:0] {
    SIPM_PAT_SLOW,
    SIPM_PAT_STBY,
    SIPM_PAT_FAST,
    SIPM_PAT_HIGH
  } sipm_pat_t;

  typedef enum logic [2:0] {
    SIPM_OFF,
    SIPM_STANDBY,
    SIPM_XFER,
    SIPM_SLEEP,
    SIPM_DEEP
  } sipm_mode_t;
endpackage : sipm_pkg

// ===== design/sipm_blink.sv
// sipm_blink: network indicator pattern generator
// assumes a one-cycle millisecond tick from the same clock domain
`timescale 1ns/1ps
module sipm_blink
  import sipm_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // timing and selection
  input wire logic i_ms_tick,
  input wire sipm_pat_t i_pat,
  // indicator
  output logic o_led
);
  typedef struct packed {
    sipm_pat_t pat;
    logic led;
    logic [11:0] cnt;
  } sipm_blink_st_t;

  sipm_blink_st_t st;
  sipm_blink_st_t next_st;

  // phase length in ms for a pattern and phase
  function automatic logic [11:0] phase_ms(input sipm_pat_t p, input logic hi);
    case (p)
      SIPM_PAT_SLOW: phase_ms = hi ? 12'(SLOW_ON_MS) : 12'(SLOW_OFF_MS);
      SIPM_PAT_STBY: phase_ms = hi ? 12'(STBY_ON_MS) : 12'(STBY_OFF_MS);
      SIPM_PAT_FAST: phase_ms = 12'(FAST_MS);
      default: phase_ms = 12'h001;
    endcase
  endfunction

  // phase timer; a pattern change restarts on a fresh high phase
  always_comb begin
    next_st = st;
    if (i_pat != st.pat) begin
      next_st.pat = i_pat;
      next_st.led = 1'b1;
      next_st.cnt = 12'h000;
    end else if (st.pat == SIPM_PAT_HIGH) begin
      next_st.led = 1'b1;
      next_st.cnt = 12'h000;
    end else if (i_ms_tick) begin
      if (st.cnt + 12'h001 >= phase_ms(st.pat, st.led)) begin
        next_st.led = ~st.led;
        next_st.cnt = 12'h000;
      end else begin
        next_st.cnt = st.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{pat: SIPM_PAT_SLOW, led: 1'b1, cnt: 12'h000};
    end else begin
      st <= next_st;
    end
  end

  assign o_led = st.led;
endmodule // sipm_blink

// ===== design/sipm_top.sv
// sipm_top: operating mode control, indicator outputs, flight and sleep control
// assumes command strobes come from the host command parser on the same clock;
// pins (radio-off, sleep control, dtr, wake, power button) are asynchronous
`timescale 1ns/1ps
module sipm_top
  import sipm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_TICK_CYCLES,
  parameter int unsigned ADC_W = ADC_BITS
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // pins from the host board
  input wire logic i_radio_off_pin_n,
  input wire logic i_sleep_ctrl_pin,
  input wire logic i_sleep_ctrl_present,
  input wire logic i_dtr_pin,
  input wire logic i_deep_save_wake_pin,
  input wire logic i_power_button_n,
  // network and modem state
  input wire logic i_sim_present,
  input wire logic i_pin_pending,
  input wire logic i_registered,
  input wire logic i_reg_failed,
  input wire logic i_data_setup,
  input wire logic i_xfer_start,
  input wire logic i_xfer_done,
  input wire logic i_tau_due,
  input wire logic i_uplink_sent,
  input wire logic i_downlink_valid,
  input wire logic i_shutdown_req,
  input wire logic i_deep_save_req,
  // host commands, one-cycle strobes with data
  input wire logic i_serial_cmd,
  input wire logic i_radio_off_pin_enable_cmd,
  input wire logic i_radio_off_pin_enable_val,
  input wire logic i_func_cmd,
  input wire logic [3:0] i_func_val,
  input wire logic i_sleep_pin_polarity_cmd,
  input wire logic i_sleep_pin_polarity_val,
  input wire logic i_slow_clock_enable_cmd,
  input wire logic i_slow_clock_enable_val,
  input wire logic i_sleep_delay_cmd,
  input wire logic [7:0] i_sleep_delay_val,
  input wire logic i_adc_read_cmd,
  input wire logic i_adc_read_chan,
  input wire logic [ADC_W-1:0] i_adc0_code,
  input wire logic [ADC_W-1:0] i_adc1_code,
  // indicator outputs
  output logic o_network_indicator,
  output logic o_status,
  // power and radio control
  output logic o_radio_en,
  output logic o_baseband_pwr,
  output logic o_serial_en,
  output logic o_downlink_accept,
  output logic o_flight,
  output sipm_mode_t o_mode,
  // adc answer
  output logic o_adc_valid,
  output logic [ADC_W-1:0] o_adc_data
);
  // elaboration checks: the divider and the adc path serve only these ranges
  if (MS_CYCLES < 2 || ADC_W < 1 || ADC_W > 16) begin : g_bad_params
    $error("sipm_top: unsupported parameter values");
  end
  // registration window must fit the 14-bit window counter
  if (REG_WINDOW_MS > 16383) begin : g_bad_window
    $error("sipm_top: registration window too long");
  end
  // longest programmed delay must fit the 18-bit delay counter
  if (255 * SLEEP_DELAY_UNIT_MS > 262143) begin : g_bad_delay
    $error("sipm_top: sleep delay unit too long");
  end

  // the block counts as powered in every mode but shutdown
  function automatic logic is_on(input sipm_mode_t m);
    is_on = (m != SIPM_OFF);
  endfunction

  typedef struct packed {
    // pin synchronisers, two stages each
    logic [1:0] rof_s;
    logic [1:0] slp_s;
    logic [1:0] dtr_s;
    logic [1:0] wk_s;
    logic [1:0] pb_s;
    // millisecond divider
    logic [31:0] div;
    logic ms_tick;
    // configuration
    logic rof_en;
    logic sw_flight;
    logic pol_pend;
    logic pol_act;
    logic [7:0] delay_s;
    // timers
    logic delay_run;
    logic [17:0] delay_ms;
    logic [13:0] reg_ms;
    logic reg_slow;
    logic dl_open;
    // mode and outputs
    sipm_mode_t mode;
    logic status;
    logic radio_en;
    logic bb_pwr;
    logic ser_en;
    logic dl_acc;
    logic flight;
    logic adc_valid;
    logic [ADC_W-1:0] adc_data;
  } sipm_st_t;

  sipm_st_t st;
  sipm_st_t next_st;
  sipm_pat_t pat;
  logic led;
  logic sleep_level;
  logic sleep_req;
  logic flight_now;

  // chosen sleep control source, then polarity decode
  always_comb begin
    sleep_level = i_sleep_ctrl_present ? st.slp_s[1] : st.dtr_s[1];
    // polarity 0: high sleeps; polarity 1: low sleeps
    sleep_req = st.pol_act ? ~sleep_level : sleep_level;
    // pin only counts once enabled; undriven pin reads high on board pull-up
    flight_now = st.sw_flight | (st.rof_en & ~st.rof_s[1]);
  end

  // indicator pattern selection from mode and network state
  always_comb begin
    if (st.mode == SIPM_SLEEP || st.mode == SIPM_DEEP) begin
      pat = SIPM_PAT_HIGH;
    end else if (i_data_setup) begin
      pat = SIPM_PAT_FAST;
    end else if (!i_sim_present || i_pin_pending || i_reg_failed) begin
      pat = SIPM_PAT_SLOW;
    end else if (!i_registered && st.reg_slow) begin
      pat = SIPM_PAT_SLOW;
    end else if (!i_registered) begin
      // past the window only the network can declare failure; keep the slow blink meanwhile
      pat = SIPM_PAT_SLOW;
    end else begin
      pat = SIPM_PAT_STBY;
    end
  end

  always_comb begin
    next_st = st;
    // pins pass two flops before any logic reads them
    next_st.rof_s = {st.rof_s[0], i_radio_off_pin_n};
    next_st.slp_s = {st.slp_s[0], i_sleep_ctrl_pin};
    next_st.dtr_s = {st.dtr_s[0], i_dtr_pin};
    next_st.wk_s = {st.wk_s[0], i_deep_save_wake_pin};
    next_st.pb_s = {st.pb_s[0], i_power_button_n};

    // millisecond tick divider
    next_st.ms_tick = 1'b0;
    if (st.div >= MS_CYCLES - 1) begin
      next_st.div = '0;
      next_st.ms_tick = 1'b1;
    end else begin
      next_st.div = st.div + 32'h1;
    end

    // command decode
    if (i_radio_off_pin_enable_cmd) begin
      next_st.rof_en = i_radio_off_pin_enable_val;
    end
    // values other than enter and leave are ignored
    if (i_func_cmd && i_func_val == FUNC_FLIGHT) begin
      next_st.sw_flight = 1'b1;
    end else if (i_func_cmd && i_func_val == FUNC_FULL) begin
      next_st.sw_flight = 1'b0;
    end
    // polarity is staged and only committed by slow-clock enable
    if (i_sleep_pin_polarity_cmd) begin
      next_st.pol_pend = i_sleep_pin_polarity_val;
    end
    if (i_slow_clock_enable_cmd && i_slow_clock_enable_val) begin
      next_st.pol_act = i_sleep_pin_polarity_cmd ? i_sleep_pin_polarity_val
                                                 : st.pol_pend;
    end
    // delay held only in flops, so lost at power removal
    if (i_sleep_delay_cmd) begin
      next_st.delay_s = i_sleep_delay_val;
      next_st.delay_run = 1'b1;
      next_st.delay_ms = '0;
    end

    // registration window: slow blink first 15 s, tracked for the indicator pattern
    // window counter holds at its end so it never wraps
    if (i_registered || !i_sim_present) begin
      next_st.reg_ms = '0;
    end else if (st.ms_tick && st.reg_ms < 14'(REG_WINDOW_MS)) begin
      next_st.reg_ms = st.reg_ms + 14'h1;
    end
    next_st.reg_slow = st.reg_ms < 14'(REG_WINDOW_MS);

    // programmed sleep delay count in ms; it saturates so a long
    // transfer or sleep cannot wrap it round to a small value
    if (st.delay_run && !i_sleep_delay_cmd && st.ms_tick && st.delay_ms != 18'h3ffff) begin
      next_st.delay_ms = st.delay_ms + 18'h1;
    end

    // adc answer, code already spans zero to battery
    next_st.adc_valid = i_adc_read_cmd;
    if (i_adc_read_cmd) begin
      next_st.adc_data = i_adc_read_chan ? i_adc1_code : i_adc0_code;
    end

    // mode machine
    case (st.mode)
      SIPM_OFF: begin
        // power-on and shutdown both restart here and land in standby
        next_st.mode = SIPM_STANDBY;
      end
      SIPM_STANDBY: begin
        // deep save request outranks level sleep and programmed sleep
        if (i_deep_save_req) begin
          next_st.mode = SIPM_DEEP;
        end else if (sleep_req && !i_serial_cmd) begin
          next_st.mode = SIPM_SLEEP;
        end else if (st.delay_run && !i_serial_cmd &&
                     st.delay_ms >= 18'(32'(st.delay_s) * SLEEP_DELAY_UNIT_MS)) begin
          // timer stays armed through sleep so the pin wake level cannot undo it
          next_st.mode = SIPM_SLEEP;
        end else if (i_xfer_start && !flight_now) begin
          // flight blocks entry so no transfer starts with the radio off
          next_st.mode = SIPM_XFER;
        end
      end
      SIPM_XFER: begin
        // only the end of the transfer or a shutdown leaves this mode
        if (i_xfer_done) begin
          next_st.mode = SIPM_STANDBY;
        end
      end
      SIPM_SLEEP: begin
        // a command on the serial port, or the pin's wake level when no delay is armed, ends sleep
        if (i_serial_cmd || (!sleep_req && !st.delay_run)) begin
          next_st.mode = SIPM_STANDBY;
          next_st.delay_run = 1'b0;
        end
      end
      SIPM_DEEP: begin
        // wake pin, power button and a due area update each end deep save
        if (st.wk_s[1]) begin
          next_st.mode = SIPM_STANDBY;
        end else if (!st.pb_s[1] || i_tau_due) begin
          next_st.mode = SIPM_STANDBY;
        end
      end
      default: begin
        next_st.mode = SIPM_STANDBY;
      end
    endcase
    // shutdown outranks every other transition
    if (i_shutdown_req) begin
      next_st.mode = SIPM_OFF;
    end

    // downlink gate in deep save: opens only after own uplink
    if (st.mode != SIPM_DEEP) begin
      next_st.dl_open = 1'b0;
    end else if (i_uplink_sent) begin
      next_st.dl_open = 1'b1;
    end
    // outside deep save downlink passes straight through, one cycle late
    next_st.dl_acc = (st.mode != SIPM_DEEP) ? i_downlink_valid
                                            : (st.dl_open & i_downlink_valid);

    // power and radio outputs
    next_st.flight = flight_now;
    next_st.radio_en = !flight_now && is_on(st.mode);
    next_st.bb_pwr = is_on(st.mode);
    next_st.ser_en = is_on(st.mode);
    next_st.status = is_on(st.mode);
  end

  // asynchronous reset loads constants only; pin stages start at their idle levels
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{rof_s: 2'h3, slp_s: 2'h0, dtr_s: 2'h0, wk_s: 2'h0, pb_s: 2'h3,
              div: 32'h0, ms_tick: 1'b0, rof_en: 1'b0, sw_flight: 1'b0,
              pol_pend: SLEEP_POL_RST, pol_act: SLEEP_POL_RST,
              delay_s: SLEEP_DELAY_RST, delay_run: 1'b0, delay_ms: 18'h0,
              reg_ms: 14'h0, reg_slow: 1'b1, dl_open: 1'b0, mode: SIPM_OFF,
              status: 1'b0, radio_en: 1'b0, bb_pwr: 1'b0, ser_en: 1'b0,
              dl_acc: 1'b0, flight: 1'b0, adc_valid: 1'b0, adc_data: '0};
    end else begin
      st <= next_st;
    end
  end

  // indicator blink engine, restarts on pattern change
  sipm_blink u_blink (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ms_tick(st.ms_tick),
    .i_pat(pat),
    .o_led(led)
  );

  // every output is a bare flop, here or in the blink engine
  assign o_network_indicator = led;
  assign o_status = st.status;
  // power, radio and adc outputs
  assign o_radio_en = st.radio_en;
  assign o_baseband_pwr = st.bb_pwr;
  assign o_serial_en = st.ser_en;
  assign o_downlink_accept = st.dl_acc;
  assign o_flight = st.flight;
  assign o_mode = st.mode;
  assign o_adc_valid = st.adc_valid;
  assign o_adc_data = st.adc_data;
endmodule // sipm_top

// ===== dv/sipm_chk_assertions.sv
// sipm_chk: port-level checks for sipm_top
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module sipm_chk
  import sipm_pkg::*;
#(
  parameter int unsigned ADC_W = ADC_BITS
) (
  // clock, reset and watched inputs
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_func_cmd,
  input wire logic [3:0] i_func_val,
  input wire logic i_serial_cmd,
  input wire logic i_xfer_done,
  input wire logic i_deep_save_wake_pin,
  input wire logic i_adc_read_cmd,
  input wire logic i_adc_read_chan,
  input wire logic [ADC_W-1:0] i_adc0_code,
  input wire logic [ADC_W-1:0] i_adc1_code,
  // watched outputs
  input wire logic o_network_indicator,
  input wire logic o_status,
  input wire logic o_radio_en,
  input wire logic o_baseband_pwr,
  input wire logic o_serial_en,
  input wire logic o_flight,
  input wire sipm_mode_t o_mode,
  input wire logic o_adc_valid,
  input wire logic [ADC_W-1:0] o_adc_data
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // power outputs lag the mode by one flop, so two on-cycles are needed
  property p_power;
    o_mode != SIPM_OFF && $past(o_mode) != SIPM_OFF |-> o_status && o_baseband_pwr && o_serial_en;
  endproperty
  a_power: assert property (p_power) else $error("power low while on");
  property p_adc;
    i_adc_read_cmd |=> o_adc_valid && o_adc_data == ($past(i_adc_read_chan) ?
      $past(i_adc1_code) : $past(i_adc0_code));
  endproperty
  a_adc: assert property (p_adc) else $error("adc answer wrong");
  property p_flight;
    i_func_cmd && i_func_val == FUNC_FLIGHT |-> ##2 o_flight;
  endproperty
  a_flight: assert property (p_flight) else $error("flight not entered");
  property p_radio;
    o_flight |-> !o_radio_en;
  endproperty
  a_radio: assert property (p_radio) else $error("radio on in flight");
  property p_sleep_led;
    o_mode == SIPM_SLEEP [*3] |-> o_network_indicator;
  endproperty
  a_sleep_led: assert property (p_sleep_led) else $error("led low in sleep");
  property p_deep_wake;
    o_mode == SIPM_DEEP && i_deep_save_wake_pin |-> ##[1:4] o_mode == SIPM_STANDBY;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("no deep wake");
  property p_serial_wake;
    o_mode == SIPM_SLEEP && i_serial_cmd |=> o_mode == SIPM_STANDBY;
  endproperty
  a_serial_wake: assert property (p_serial_wake) else $error("no serial wake");
  property p_xfer;
    o_mode == SIPM_XFER && i_xfer_done |=> o_mode == SIPM_STANDBY;
  endproperty
  a_xfer: assert property (p_xfer) else $error("no standby after xfer");
endmodule // sipm_chk

bind sipm_top sipm_chk #(.ADC_W(ADC_W)) u_chk (.*);

// ===== dv/sipm_host.sv
// sipm_host: behavioural host driving pins and command strobes
// assumes the design clock; changes land at the falling edge
`timescale 1ns/1ps
module sipm_host (
  // clock
  input wire logic i_core_clk,
  // strobes: serial, pin enable, func, polarity, slow clock, delay
  output logic [5:0] o_cmd,
  output logic [7:0] o_val,
  // pins: button_n, wake, dtr, sleep, radio-off_n
  output logic [4:0] o_pin
);
  // radio-off line idles high as if pulled up, button released
  initial begin
    o_cmd = 6'h00;
    o_val = 8'h00;
    o_pin = 5'h11;
  end
  // one-cycle strobe; value then inverted so stale data never matches
  task automatic cmd(input int k, input logic [7:0] v);
    @(negedge i_core_clk);
    o_cmd[k] = 1'h1;
    o_val = v;
    @(negedge i_core_clk);
    o_cmd[k] = 1'h0;
    o_val = ~v;
  endtask
  // pin levels hold until changed
  task automatic pin(input int k, input logic v);
    @(negedge i_core_clk);
    o_pin[k] = v;
  endtask
endmodule // sipm_host

// ===== dv/tb_top.sv
// tb_top: self-checking bench for sipm_top with a behavioural host
// assumes 100 MHz clock and a millisecond tick shortened to MS cycles
`timescale 1ns/1ps
module tb_top;
  import sipm_pkg::*;
  localparam int MS = 10;
  // modem-side inputs, named as the design ports
  logic i_core_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_sleep_ctrl_present = 1'h1, i_sim_present = 1'h1, i_pin_pending = 1'h0;
  logic i_registered = 1'h1, i_reg_failed = 1'h0, i_data_setup = 1'h0;
  logic i_xfer_start = 1'h0, i_xfer_done = 1'h0, i_tau_due = 1'h0, i_uplink_sent = 1'h0;
  logic i_downlink_valid = 1'h0, i_shutdown_req = 1'h0, i_deep_save_req = 1'h0;
  logic i_adc_read_cmd = 1'h0, i_adc_read_chan = 1'h0;
  logic [11:0] i_adc0_code = 12'h000, i_adc1_code = 12'h000;
  logic o_network_indicator, o_status, o_radio_en, o_baseband_pwr, o_serial_en;
  logic o_downlink_accept, o_flight, o_adc_valid;
  sipm_mode_t o_mode;
  logic [11:0] o_adc_data;
  logic [5:0] hc;
  logic [7:0] hv;
  logic [4:0] hp;
  int failures = 0;
  int checks_done = 0;
  sipm_host host (.i_core_clk(i_core_clk), .o_cmd(hc), .o_val(hv), .o_pin(hp));
  sipm_top #(.MS_CYCLES(MS)) DUT (
    .*,
    .i_radio_off_pin_n(hp[0]),
    .i_sleep_ctrl_pin(hp[1]),
    .i_dtr_pin(hp[2]),
    .i_deep_save_wake_pin(hp[3]),
    .i_power_button_n(hp[4]),
    .i_serial_cmd(hc[0]),
    .i_radio_off_pin_enable_cmd(hc[1]),
    .i_radio_off_pin_enable_val(hv[0]),
    .i_func_cmd(hc[2]),
    .i_func_val(hv[3:0]),
    .i_sleep_pin_polarity_cmd(hc[3]),
    .i_sleep_pin_polarity_val(hv[0]),
    .i_slow_clock_enable_cmd(hc[4]),
    .i_slow_clock_enable_val(hv[0]),
    .i_sleep_delay_cmd(hc[5]),
    .i_sleep_delay_val(hv)
  );
  // free-running core clock
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // first phase may be a tick short, and the pattern select adds a few cycles
  task automatic chk_near(input string nm, input int e, input int g);
    checks_done++;
    if (g < e - MS - 3 || g > e + 3) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic pulse(ref logic s);
    cyc(1);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask
  // time the fresh high phase after a pattern change, then the low phase
  task automatic blink(input string nm, input int hi, input int lo);
    int n;
    n = 3;
    cyc(3);
    while (o_network_indicator === 1'h1 && n < 30000) begin
      cyc(1);
      n++;
    end
    chk_near({nm, " high"}, hi * MS, n);
    n = 0;
    while (o_network_indicator === 1'h0 && n < 30000) begin
      cyc(1);
      n++;
    end
    chk_near({nm, " low"}, lo * MS, n);
  endtask
  function automatic logic [11:0] adc_exp(input logic ch, input logic [11:0] c0, c1);
    return ch ? c1 : c0;
  endfunction
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog, about a third above the expected 75k cycles
  initial begin
    repeat (100000) @(posedge i_core_clk);
    failures++;
    final_report();
  end
  // main sequence
  initial begin
    int v;
    void'($urandom(82));
    cyc(2);
    i_rst_n = 1'h1;
    cyc(3);
    chk("mode", SIPM_STANDBY, o_mode);
    chk("status", 1'h1, o_status);
    v = $urandom_range(2);
    i_registered = 1'h0;
    i_sim_present = (v != 0);
    i_pin_pending = (v == 1);
    i_reg_failed = (v == 2);
    blink("slow", 200, 1800);
    {i_sim_present, i_pin_pending, i_reg_failed, i_registered} = 4'h9;
    blink("standby", 1800, 200);
    i_data_setup = 1'h1;
    blink("fast", 120, 120);
    i_data_setup = 1'h0;
    $display("test blink done");
    host.cmd(2, 8'h04);
    cyc(3);
    chk("flight", 1'h1, o_flight);
    chk("radio", 1'h0, o_radio_en);
    v = $urandom_range(15);
    v = (v == 1 || v == 4) ? 0 : v;
    host.cmd(2, 8'(v));
    cyc(3);
    chk("bad func", 1'h1, o_flight);
    host.cmd(2, 8'h01);
    cyc(3);
    chk("flight off", 1'h0, o_flight);
    chk("radio on", 1'h1, o_radio_en);
    host.pin(0, 1'h0);
    cyc(6);
    chk("pin off", 1'h0, o_flight);
    host.cmd(1, 8'h01);
    cyc(6);
    chk("pin flight", 1'h1, o_flight);
    host.pin(0, 1'h1);
    cyc(6);
    chk("pin normal", 1'h0, o_flight);
    $display("test flight done");
    pulse(i_xfer_start);
    cyc(2);
    chk("xfer", SIPM_XFER, o_mode);
    pulse(i_xfer_done);
    cyc(2);
    chk("xfer end", SIPM_STANDBY, o_mode);
    for (int i = 0; i < 8; i++) begin
      i_adc0_code = 12'($urandom);
      i_adc1_code = 12'($urandom);
      i_adc_read_chan = 1'($urandom);
      pulse(i_adc_read_cmd);
      chk("adc valid", 1'h1, o_adc_valid);
      chk("adc", adc_exp(i_adc_read_chan, i_adc0_code, i_adc1_code), o_adc_data);
    end
    $display("test xfer adc done");
    host.pin(1, 1'h1);
    cyc(6);
    chk("pol0 sleep", SIPM_SLEEP, o_mode);
    host.pin(1, 1'h0);
    cyc(6);
    chk("pol0 wake", SIPM_STANDBY, o_mode);
    host.cmd(3, 8'h01);
    cyc(6);
    chk("pol pend", SIPM_STANDBY, o_mode);
    host.cmd(4, 8'h01);
    cyc(6);
    chk("pol1 sleep", SIPM_SLEEP, o_mode);
    host.pin(1, 1'h1);
    cyc(6);
    chk("pol1 wake", SIPM_STANDBY, o_mode);
    i_sleep_ctrl_present = 1'h0;
    cyc(6);
    chk("dtr sleep", SIPM_SLEEP, o_mode);
    host.pin(2, 1'h1);
    cyc(6);
    chk("dtr wake", SIPM_STANDBY, o_mode);
    $display("test sleep pin done");
    i_downlink_valid = 1'h1;
    for (int w = 0; w < 3; w++) begin
      pulse(i_deep_save_req);
      cyc(4);
      chk("deep", SIPM_DEEP, o_mode);
      chk("dl gated", 1'h0, o_downlink_accept);
      if (w == 0) begin
        pulse(i_uplink_sent);
        cyc(3);
        chk("dl open", 1'h1, o_downlink_accept);
        host.pin(3, 1'h1);
      end else if (w == 1) begin
        host.pin(4, 1'h0);
      end else begin
        pulse(i_tau_due);
      end
      cyc(6);
      chk("deep left", SIPM_STANDBY, o_mode);
      host.pin(3, 1'h0);
      host.pin(4, 1'h1);
    end
    i_downlink_valid = 1'h0;
    pulse(i_shutdown_req);
    chk("off", SIPM_OFF, o_mode);
    cyc(1);
    chk("bb off", 1'h0, o_baseband_pwr);
    chk("uart off", 1'h0, o_serial_en);
    cyc(3);
    chk("restart", SIPM_STANDBY, o_mode);
    $display("test deep shutdown done");
    host.cmd(5, 8'h02);
    cyc(19000);
    chk("delay wait", SIPM_STANDBY, o_mode);
    cyc(2000);
    chk("delay sleep", SIPM_SLEEP, o_mode);
    host.cmd(0, 8'h00);
    chk("serial wake", SIPM_STANDBY, o_mode);
    $display("test delay done");
    // arm a 1 s delay, then cut power mid-run: the delay must not survive
    host.cmd(5, 8'h01);
    host.pin(2, 1'h0);
    cyc(6);
    chk("pol1 dtr sleep", SIPM_SLEEP, o_mode);
    i_rst_n = 1'h0;
    cyc(1);
    chk("rst status", 1'h0, o_status);
    cyc(1);
    i_rst_n = 1'h1;
    cyc(3);
    chk("rst standby", SIPM_STANDBY, o_mode);
    cyc(11000);
    chk("delay lost", SIPM_STANDBY, o_mode);
    $display("test power loss done");
    final_report();
  end
endmodule // tb_top
